// [logic/reset_supervisor_pkg.sv]
/*
  Shared constants and types for the reset and brown-out supervisor:
  wake-up counts, supply filter timing, boot fetch address, state codes.
  Assumes a single 100 MHz supervisor clock.
*/
package reset_supervisor_pkg;

  // Clock rate
  localparam int CLK_PERIOD_NS    = 10;

  // Wake-up timer lengths in clock cycles
  localparam int WAKE_CYCLES_XTAL = 4096;
  localparam int WAKE_CYCLES_IRC  = 4;

  // Digital hysteresis time on the supply levels, rounded up to cycles
  localparam int HYST_TIME_NS     = 1000;
  localparam int HYST_CYCLES      = (HYST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Supply thresholds in millivolts, realised by the analog comparators
  localparam int BOD_IRQ_MV       = 2200;
  localparam int BOD_RESET_MV     = 1850;
  localparam int POR_MV           = 1000;

  // First fetch address after internal reset is removed
  localparam logic [31:0] BOOT_FETCH_ADDR = 32'h0000_0000;

  // Bit positions of the synchronised source vector
  localparam int SRC_IRQ          = 0;
  localparam int SRC_BOD_RST      = 1;
  localparam int SRC_POR          = 2;
  localparam int SRC_EXT          = 3;
  localparam int CMP_NUM          = 3;
  localparam int SRC_NUM          = 4;

  // All sources read as asserted until the synchroniser has filled
  localparam logic [SRC_NUM-1:0] SRC_RESET_VALUE = 4'hF;

  // Raw analog comparator outputs, high when the supply is below the level
  typedef struct packed {
    logic below_por;
    logic below_rst;
    logic below_irq;
  } supply_comp_type;

  // Brown-out status toward the interrupt side
  typedef struct packed {
    logic irq;
    logic status;
  } bod_report_type;

  // Supervisor sequence states
  typedef enum logic [3:0] {
    ST_HOLD  = 4'h1,
    ST_WAKE  = 4'h2,
    ST_FLASH = 4'h4,
    ST_RUN   = 4'h8
  } sup_state_type;

endpackage : reset_supervisor_pkg

// [logic/level_sync.sv]
/*
  Two-stage level synchroniser, one generate lane per bit.
  Assumes inputs are quasi-static levels; pulses shorter than one clock may be lost.
*/
`timescale 1ns/10ps
module level_sync #(
  parameter int                WIDTH     = 4,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_lane
      logic meta_reg;
      logic safe_reg;
      // First flop feeds only the second one
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          meta_reg <= RESET_VAL[g];
          safe_reg <= RESET_VAL[g];
        end else begin
          meta_reg <= async_i[g];
          safe_reg <= meta_reg;
        end
      end
      assign sync_o[g] = safe_reg;
    end
  endgenerate

endmodule : level_sync

// [logic/reset_brownout_supervisor.sv]
/*
  Chip reset and brown-out supervisor: merges the reset sources, runs the
  wake-up timer, sequences release of internal reset and the reset output
  pin, and reports the first brown-out stage.
  Assumes raw comparator outputs and the external reset pin are asynchronous;
  oscillator, flash, watchdog and wake inputs are synchronous to clock_i.
  rst_n_i comes from the power-on cell and is synchronous.
*/
// Contract
// - Four sources each reset the chip
// - Reset drives pin low, starts timer
// - Release needs pin, oscillator, count, flash
// - Pin high after release or supply recovery
// - Fetch starts at boot address zero
// - All registers reset before release
// - Below first level raises brown-out interrupt
// - Interrupt gated by enable, level readable
// - Below second level resets, blocks flash
// - Power-on reset holds below lowest level
// - Brown-out levels filtered with hysteresis
// - External wake leaves power-down mode
// - Wake timer counts 4096 or 4
`timescale 1ns/10ps
module reset_brownout_supervisor
  import reset_supervisor_pkg::*;
#(
  parameter int WAKE_XTAL_CYCLES   = WAKE_CYCLES_XTAL,
  parameter int WAKE_IRC_CYCLES    = WAKE_CYCLES_IRC,
  parameter int HYST_FILTER_CYCLES = HYST_CYCLES
) (
  input  wire logic            clock_i,
  input  wire logic            rst_n_i,
  input  wire logic            ext_reset_n_i,
  input  wire logic            watchdog_reset_i,
  input  wire supply_comp_type supply_comp_i,
  input  wire logic            osc_running_i,
  input  wire logic            osc_sel_irc_i,
  input  wire logic            flash_init_done_i,
  input  wire logic            bod_irq_enable_i,
  input  wire logic            power_down_i,
  input  wire logic            ext_wake_sel_i,
  input  wire logic            ext_wake_en_i,
  input  wire logic            ext_wake_req_i,
  output logic                 reset_out_pin_o,
  output logic                 chip_reset_n_o,
  output logic [31:0]          cpu_fetch_addr_o,
  output logic                 brownout_irq_o,
  output logic                 brownout_status_o,
  output logic                 flash_write_block_o,
  output logic                 wake_o
);

  localparam int CNT_W = $clog2(WAKE_XTAL_CYCLES + 1);
  localparam int HF_W  = $clog2(HYST_FILTER_CYCLES + 1);
  localparam logic [CNT_W-1:0] XTAL_LAST = CNT_W'(WAKE_XTAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] IRC_LAST  = CNT_W'(WAKE_IRC_CYCLES - 1);
  localparam logic [HF_W-1:0]  HF_LAST   = HF_W'(HYST_FILTER_CYCLES - 1);

  logic [SRC_NUM-1:0] raw_vec;
  logic [SRC_NUM-1:0] sync_vec;
  logic [CMP_NUM-1:0] filt_lvl;
  logic               ext_active;
  logic               irq_lvl;
  logic               bod_rst_lvl;
  logic               por_lvl;
  logic               src_active;
  logic               async_hold;
  sup_state_type      state_reg;
  logic [CNT_W-1:0]   wake_cnt_reg;
  logic [CNT_W-1:0]   wake_limit_reg;
  logic [31:0]        fetch_addr_reg;
  bod_report_type     bod_reg;
  logic               wake_reg;

  // Active-high view of every asynchronous source
  assign raw_vec = {~ext_reset_n_i, supply_comp_i.below_por,
                    supply_comp_i.below_rst, supply_comp_i.below_irq};

  // Bring pin and comparator levels into the clock domain
  level_sync #(
    .WIDTH     (SRC_NUM),
    .RESET_VAL (SRC_RESET_VALUE)
  ) u_src_sync (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .async_i   (raw_vec),
    .sync_o    (sync_vec)
  );

  // Supply levels change only after staying put for the filter time,
  // so a supply hovering at a threshold cannot chatter the brown-out outputs; reset and flash block also follow raw levels
  genvar g;
  generate
    for (g = 0; g < CMP_NUM; g++) begin : gen_filt
      logic            lvl_reg;
      logic [HF_W-1:0] cnt_reg;
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          lvl_reg <= 1'b1;
          cnt_reg <= '0;
        end else if (sync_vec[g] == lvl_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg == HF_LAST) begin
          lvl_reg <= sync_vec[g];
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
      assign filt_lvl[g] = lvl_reg;
    end
  endgenerate

  // Source merge
  assign ext_active  = sync_vec[SRC_EXT];
  assign irq_lvl     = filt_lvl[SRC_IRQ];
  assign bod_rst_lvl = filt_lvl[SRC_BOD_RST];
  assign por_lvl     = filt_lvl[SRC_POR];
  assign src_active  = ext_active | por_lvl | bod_rst_lvl | watchdog_reset_i;

  // Raw levels pull reset at once, without waiting for the synchroniser
  assign async_hold  = ~ext_reset_n_i | supply_comp_i.below_por
                     | supply_comp_i.below_rst;

  // Reset sequence; any active source restarts it from the hold state
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_HOLD;
    end else if (src_active) begin
      state_reg <= ST_HOLD;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          state_reg <= ST_WAKE;
        end
        ST_WAKE: begin
          if ((wake_cnt_reg == wake_limit_reg) && osc_running_i) begin
            state_reg <= ST_FLASH;
          end
        end
        ST_FLASH: begin
          if (flash_init_done_i) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  // Wake-up timer length follows the selected clock source, taken in hold
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wake_limit_reg <= XTAL_LAST;
    end else if (state_reg == ST_HOLD) begin
      wake_limit_reg <= osc_sel_irc_i ? IRC_LAST : XTAL_LAST;
    end
  end

  // Wake-up timer; it saturates so a slow oscillator simply waits
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || (state_reg != ST_WAKE)) begin
      wake_cnt_reg <= '0;
    end else if (wake_cnt_reg != wake_limit_reg) begin
      wake_cnt_reg <= wake_cnt_reg + 1'b1;
    end
  end

  // Internal reset: asserted immediately, released only from the run state.
  // Synchronised sources gate it too: a short dip can clear its raw level just
  // as the filtered copy sets, and the pin must not blip high for that cycle.
  assign chip_reset_n_o  = (state_reg == ST_RUN) & ~src_active & ~async_hold;
  // Pin follows internal reset, so a brown-out reset holds it until recovery
  assign reset_out_pin_o = chip_reset_n_o;

  // Fetch address pinned to the boot vector while reset is held
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || (state_reg != ST_RUN)) begin
      fetch_addr_reg <= BOOT_FETCH_ADDR;
    end
  end
  assign cpu_fetch_addr_o = fetch_addr_reg;

  // First-stage report: status always visible, interrupt only when enabled
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bod_reg <= '0;
    end else begin
      bod_reg.status <= irq_lvl;
      bod_reg.irq    <= irq_lvl & bod_irq_enable_i;
    end
  end
  assign brownout_irq_o    = bod_reg.irq;
  assign brownout_status_o = bod_reg.status;

  // Flash writes blocked from the raw edge until the filtered level clears
  assign flash_write_block_o = supply_comp_i.below_rst | bod_rst_lvl | por_lvl;

  // Wake request from the selected external interrupt in power-down
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= power_down_i & ext_wake_sel_i & ext_wake_en_i & ext_wake_req_i;
    end
  end
  assign wake_o = wake_reg;

  // Checks on sequencing and reporting
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // Source merge and start of the sequence; a source seen at one edge must
  // have the sequence back in hold by the next
  a_source_forces_hold: assert property (src_active |=> (state_reg == ST_HOLD))
    else $error("reset source did not force hold");
  a_watchdog_resets: assert property (watchdog_reset_i |=> !chip_reset_n_o)
    else $error("watchdog did not reset the chip");
  a_timer_starts: assert property (
    (state_reg == ST_HOLD) && !src_active
      |=> (state_reg == ST_WAKE) && (wake_cnt_reg == '0))
    else $error("wake timer did not start after hold");
  a_pin_low_in_hold: assert property (
    (state_reg != ST_RUN) |-> !reset_out_pin_o)
    else $error("reset pin high while sequence not done");

  // Release conditions; each gate must hold the sequence on its own
  a_release_needs_flash: assert property (
    $rose(state_reg == ST_RUN) |-> $past(flash_init_done_i) && $past(state_reg == ST_FLASH))
    else $error("reset released without flash ready");
  a_timer_complete: assert property (
    $rose(state_reg == ST_FLASH) |-> $past(wake_cnt_reg) == $past(wake_limit_reg)
                                      && $past(osc_running_i))
    else $error("timer or oscillator not done at flash step");
  a_osc_gates: assert property (
    (state_reg == ST_WAKE) && !osc_running_i && !src_active |=> (state_reg == ST_WAKE))
    else $error("wake step left without a running oscillator");
  a_flash_gates: assert property (
    (state_reg == ST_FLASH) && !flash_init_done_i && !src_active |=> (state_reg == ST_FLASH))
    else $error("flash step left before initialisation done");
  a_ext_holds: assert property (!ext_reset_n_i |-> !chip_reset_n_o)
    else $error("chip left reset while external reset held");

  // Wake-up timer
  a_wake_length: assert property (
    (state_reg == ST_HOLD) && !src_active && osc_sel_irc_i
      |=> (wake_limit_reg == IRC_LAST))
    else $error("wrong wake count for internal oscillator");
  a_timer_bound: assert property (
    (state_reg == ST_WAKE) |-> (wake_cnt_reg <= wake_limit_reg))
    else $error("wake timer ran past its limit");

  // Brown-out and power-on reset, pin, flash protection and boot vector
  a_bod_pin_low: assert property (bod_rst_lvl |-> !reset_out_pin_o)
    else $error("reset pin high during brown-out reset");
  a_boot_address: assert property (
    $rose(chip_reset_n_o) |-> (cpu_fetch_addr_o == BOOT_FETCH_ADDR))
    else $error("fetch address not boot vector at release");
  a_flash_blocked: assert property (
    supply_comp_i.below_rst |-> flash_write_block_o && !chip_reset_n_o)
    else $error("second stage did not reset and block flash");
  a_bod_blocks: assert property (bod_rst_lvl |-> flash_write_block_o)
    else $error("flash not blocked during brown-out reset");
  a_por_holds: assert property (supply_comp_i.below_por |-> !chip_reset_n_o)
    else $error("power-on level did not hold reset");

  // First-stage report
  a_irq_enabled: assert property (irq_lvl && bod_irq_enable_i |=> brownout_irq_o)
    else $error("brown-out interrupt missing");
  a_irq_masked: assert property (!bod_irq_enable_i |=> !brownout_irq_o)
    else $error("brown-out interrupt not masked");
  a_status_level: assert property (irq_lvl |=> brownout_status_o)
    else $error("brown-out status not visible");
  a_status_clears: assert property (!irq_lvl |=> !brownout_status_o)
    else $error("brown-out status stuck after recovery");
  a_hyst_filter: assert property (
    $changed(irq_lvl) |-> $past(gen_filt[SRC_IRQ].cnt_reg) == HF_LAST)
    else $error("supply level changed before filter time");

  // Wake request and synchronised release of the external pin
  a_wake_out: assert property (
    power_down_i && ext_wake_sel_i && ext_wake_en_i && ext_wake_req_i |=> wake_o)
    else $error("external wake not raised");
  a_wake_drops: assert property (
    !(power_down_i && ext_wake_sel_i && ext_wake_en_i && ext_wake_req_i) |=> !wake_o)
    else $error("wake raised without all conditions");
  a_sync_release: assert property ($rose(ext_reset_n_i) |-> !chip_reset_n_o [*3])
    else $error("external reset released without synchronising");

  // Main scenarios worth seeing at least once
  c_reach_run:   cover property ($rose(state_reg == ST_RUN));
  c_bod_irq:     cover property ($rose(brownout_irq_o));
  c_bod_reset:   cover property ($rose(bod_rst_lvl));
  c_wdt_in_run:  cover property ((state_reg == ST_RUN) && watchdog_reset_i);
  c_wake:        cover property ($rose(wake_o));

endmodule : reset_brownout_supervisor

// [tb/board_supply_model.sv]
/*
  Board-side partner: supply rail and reset button as seen by the supervisor.
  Assumes the bench sets the rail in millivolts away from the clock edge.
*/
`timescale 1ns/10ps
module board_supply_model
  import reset_supervisor_pkg::*;
(
  input  wire logic [15:0]     supply_mv_i,
  input  wire logic            button_i,
  output logic                 ext_reset_n_o,
  output supply_comp_type      supply_comp_o
);
  // Ideal comparators; any hysteresis is the supervisor's job, not ours
  assign supply_comp_o.below_irq = (supply_mv_i < BOD_IRQ_MV);
  assign supply_comp_o.below_rst = (supply_mv_i < BOD_RESET_MV);
  assign supply_comp_o.below_por = (supply_mv_i < POR_MV);
  // Released button leaves the pin on its pull-up
  assign ext_reset_n_o = ~button_i;
endmodule : board_supply_model

// [tb/reset_brownout_supervisor_tb_top.sv]
/*
  Self-checking bench for the reset and brown-out supervisor.
  Assumes short wake and filter counts set through the top parameters.
*/
`timescale 1ns/10ps
module reset_brownout_supervisor_tb_top;
  import reset_supervisor_pkg::*;
  localparam int XTAL_N = 8;
  logic clock = 1'b0, rst_n = 1'b0, button = 1'b0, wdog = 1'b0;
  logic osc_ok = 1'b1, internal_rc_oscillator = 1'b1, flash_ok = 1'b1, irq_en = 1'b0;
  logic pd = 1'b0, wsel = 1'b0, wen = 1'b0, wreq = 1'b0;
  logic [15:0] mv = 16'h0CE4;
  logic ext_n, pin, chip_n, irq, status, fblock, wake;
  logic [31:0] fetch;
  supply_comp_type comp;
  int bad_count = 0;
  int tests_run = 0;
  int n, n_irc, n_xtal;
  // Bits 2:1 pick the source, bit 0 says flash writes must be blocked
  logic [2:0] rows [4] = '{3'b000, 3'b010, 3'b101, 3'b111};

  always #5 clock = ~clock;

  board_supply_model MODEL (.supply_mv_i(mv), .button_i(button),
    .ext_reset_n_o(ext_n), .supply_comp_o(comp));

  reset_brownout_supervisor #(.WAKE_XTAL_CYCLES(XTAL_N), .WAKE_IRC_CYCLES(WAKE_CYCLES_IRC),
    .HYST_FILTER_CYCLES(2)) DUT (
    .clock_i(clock), .rst_n_i(rst_n), .ext_reset_n_i(ext_n), .watchdog_reset_i(wdog),
    .supply_comp_i(comp), .osc_running_i(osc_ok), .osc_sel_irc_i(internal_rc_oscillator),
    .flash_init_done_i(flash_ok), .bod_irq_enable_i(irq_en), .power_down_i(pd),
    .ext_wake_sel_i(wsel), .ext_wake_en_i(wen), .ext_wake_req_i(wreq),
    .reset_out_pin_o(pin), .chip_reset_n_o(chip_n), .cpu_fetch_addr_o(fetch),
    .brownout_irq_o(irq), .brownout_status_o(status), .flash_write_block_o(fblock),
    .wake_o(wake));

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Bounded wait for internal reset to lift; a hang ends the run
  task automatic wait_release(output int k);
    k = 0;
    while (chip_n !== 1'b1) begin
      cyc(1);
      k++;
      if (k > 300) begin
        bad_count++;
        $display("[ERR] release wait expected 1 seen %b", chip_n);
        print_verdict();
      end
    end
  endtask : wait_release

  // Source codes: 0 button, 1 watchdog, 2 second stage dip, 3 collapse
  task automatic set_src(input logic [1:0] s, input logic on);
    case (s)
      2'h0: button = on;
      2'h1: wdog = on;
      2'h2: mv = on ? 16'h05DC : 16'h0CE4;
      default: mv = on ? 16'h01F4 : 16'h0CE4;
    endcase
  endtask : set_src

  // Pulse a source, then time the release of internal reset
  task automatic kick(input logic [1:0] s, output int k);
    set_src(s, 1'b1);
    cyc(3);
    set_src(s, 1'b0);
    wait_release(k);
  endtask : kick

  // Main sequence
  initial begin
    cyc(15);
    chk_bit("reset held", 1'b0, chip_n);
    chk_bit("irq in reset", 1'b0, irq);
    chk_bit("wake in reset", 1'b0, wake);
    cyc(1);
    rst_n = 1'b1;
    wait_release(n);
    chk_word("fetch address", 32'h0000_0000, fetch);
    $display("Power-up released after %0d cycles", n);
    foreach (rows[i]) begin
      set_src(rows[i][2:1], 1'b1);
      cyc(3);
      chk_bit("chip reset", 1'b0, chip_n);
      chk_bit("reset out pin", 1'b0, pin);
      chk_bit("flash block", rows[i][0], fblock);
      set_src(rows[i][2:1], 1'b0);
      wait_release(n);
      chk_bit("reset out pin", 1'b1, pin);
      chk_word("fetch address", 32'h0000_0000, fetch);
      $display("Source row %0d released after %0d cycles", i, n);
    end
    // Oscillator, then flash, holds reset past any wake count
    for (int g = 0; g < 2; g++) begin
      if (g == 0) osc_ok = 1'b0;
      else flash_ok = 1'b0;
      set_src(2'h1, 1'b1);
      cyc(1);
      set_src(2'h1, 1'b0);
      cyc(40);
      chk_bit("gated reset", 1'b0, chip_n);
      osc_ok = 1'b1;
      flash_ok = 1'b1;
      wait_release(n);
      $display("Gate test %0d done", g);
    end
    // Only the wake count differs between the two oscillator choices
    internal_rc_oscillator = 1'b1;
    kick(2'h0, n_irc);
    internal_rc_oscillator = 1'b0;
    kick(2'h0, n_xtal);
    chk_word("wake gap", 32'(XTAL_N - WAKE_CYCLES_IRC), 32'(n_xtal - n_irc));
    $display("Wake timer test done");
    // First stage: level always readable, interrupt only when enabled
    mv = 16'h076C;
    cyc(10);
    chk_bit("bod status", 1'b1, status);
    chk_bit("bod irq masked", 1'b0, irq);
    chk_bit("no reset", 1'b1, chip_n);
    irq_en = 1'b1;
    cyc(3);
    chk_bit("bod irq", 1'b1, irq);
    mv = 16'h0CE4;
    cyc(10);
    chk_bit("bod clear", 1'b0, status);
    mv = 16'h076C;
    cyc(1);
    mv = 16'h0CE4;
    cyc(10);
    chk_bit("dip filtered", 1'b0, irq);
    $display("Brown-out test done");
    // Wake needs all four conditions
    {pd, wsel, wen, wreq} = 4'hF;
    cyc(2);
    chk_bit("wake", 1'b1, wake);
    wen = 1'b0;
    cyc(2);
    chk_bit("wake off", 1'b0, wake);
    // Second power-on reset in mid-run
    rst_n = 1'b0;
    cyc(4);
    chk_bit("rerun reset", 1'b0, pin);
    rst_n = 1'b1;
    wait_release(n);
    $display("Wake and rerun tests done");
    print_verdict();
  end
endmodule : reset_brownout_supervisor_tb_top
